// ### hw/pcm_regs.sv
// pcm_regs: register file of three 16-bit pwm channels with shared enable and arm mirrors
// assumes an avalon-mm master on clk; compare and waveform logic sit outside
`timescale 1ns/1ps
// Behaviour
// - each channel keeps a 16-bit phase value as readable, writable high and low bytes
// - each channel keeps a 16-bit duty value as readable, writable high and low bytes
// - each channel keeps a 16-bit period value as readable, writable high and low bytes
// - each channel keeps a 16-bit offset value as readable, writable high and low bytes
// - the running timer reads and writes through high and low byte registers
// - count and timer bytes power up unknown and survive every other reset
// - enable mirror bits 0..2 are the same flops as each channel's enable
// - arm mirror bits 0..2 are the same flops as each channel's armed bit
// - mirror bits 7..3 ignore writes, read zero; mirrors reset to zero
// - a set enable runs the channel, a cleared one stops it
// - armed without triggered reload copies buffers into use at period end
// - hardware clears armed after the reload; software may clear it too
module pcm_regs import pcm_pkg::*; (
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    sys_rst,
    // avalon-mm slave
    input  wire logic [ADDR_W-1:0]       address,
    input  wire logic                    read,
    input  wire logic                    write,
    input  wire logic [DATA_W-1:0]       writedata,
    output logic [DATA_W-1:0]            readdata,
    output logic                         waitrequest,
    // reload triggers, one per channel
    input  wire logic [NUM_CH-1:0]       ld_trigger,
    // values in use, channel 0 in the low slice
    output logic [NUM_CH*CNT_W-1:0]      lag_active,
    output logic [NUM_CH*CNT_W-1:0]      duty_active,
    output logic [NUM_CH*CNT_W-1:0]      period_active,
    output logic [NUM_CH*CNT_W-1:0]      delay_active,
    output logic [NUM_CH*CNT_W-1:0]      timebase_count,
    // channel state
    output logic [NUM_CH-1:0]            module_on,
    output logic [NUM_CH-1:0]            reload_armed,
    output logic [NUM_CH-1:0]            period_done
);

    logic                wr_take;
    logic                rd_take;
    logic [BYTE_W-1:0]   rd_byte;
    logic [NUM_CH-1:0]   triggered_reload_select;
    logic [NUM_CH-1:0]   next_module_on;
    logic [NUM_CH-1:0]   next_ldt;
    logic [CNT_W-1:0]    buf_lag    [NUM_CH];
    logic [CNT_W-1:0]    buf_duty   [NUM_CH];
    logic [CNT_W-1:0]    buf_period [NUM_CH];
    logic [CNT_W-1:0]    buf_delay  [NUM_CH];
    logic [BYTE_W-1:0]   bank_byte  [4];

    wire [1:0]        bank          = address[BANK_MSB:BANK_LSB];
    wire [3:0]        idx           = address[IDX_MSB:IDX_LSB];
    wire [BYTE_W-1:0] wbyte         = writedata[BYTE_W-1:0];
    wire              wr_on_mirror  = wr_take & (address == OFS_MODULE_ON_MIRROR);
    wire              wr_arm_mirror = wr_take & (address == OFS_RELOAD_ARMED_MIRROR);

    // readback of one channel register
    function automatic logic [BYTE_W-1:0] pick_byte(input logic [3:0]       i,
                                                    input logic [CNT_W-1:0] lag,
                                                    input logic [CNT_W-1:0] duty,
                                                    input logic [CNT_W-1:0] per,
                                                    input logic [CNT_W-1:0] dly,
                                                    input logic [CNT_W-1:0] tmr,
                                                    input logic             on,
                                                    input logic             trig,
                                                    input logic             arm);
        logic [BYTE_W-1:0] r;
        case (i)
            IDX_LAG_HI, IDX_LAG_LO: r = get_byte(lag, ~i[0]);
            IDX_DUTY_HI, IDX_DUTY_LO: r = get_byte(duty, ~i[0]);
            IDX_PERIOD_HI, IDX_PERIOD_LO: r = get_byte(per, ~i[0]);
            IDX_DELAY_HI, IDX_DELAY_LO: r = get_byte(dly, ~i[0]);
            IDX_TMR_HI, IDX_TMR_LO: r = get_byte(tmr, ~i[0]);
            IDX_CHAN_CTRL: r = BYTE_W'(on) << CTRL_ON_BIT;
            IDX_RELOAD_CTRL: r = (BYTE_W'(arm) << RLD_ARMED_BIT) | (BYTE_W'(trig) << RLD_TRIG_BIT);
            default: r = 8'h00;
        endcase
        return r;
    endfunction

    pcm_avs u_avs (
        .clk         (clk),
        .sys_rst     (sys_rst),
        .read        (read),
        .write       (write),
        .waitrequest (waitrequest),
        .readdata    (readdata),
        .rd_byte     (rd_byte),
        .wr_take     (wr_take),
        .rd_take     (rd_take)
    );

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            wire wr_ch   = wr_take & (bank == 2'(g));
            wire wr_ctrl = wr_ch & (idx == IDX_CHAN_CTRL);
            wire wr_rld  = wr_ch & (idx == IDX_RELOAD_CTRL);

            // mirror and own control register share one flop
            assign next_module_on[g] = wr_on_mirror ? wbyte[g] :
                                       wr_ctrl ? wbyte[CTRL_ON_BIT] : module_on[g];
            assign next_ldt[g] = wr_rld ? wbyte[RLD_TRIG_BIT] : triggered_reload_select[g];
            assign bank_byte[g] = pick_byte(idx, buf_lag[g], buf_duty[g], buf_period[g],
                                            buf_delay[g], timebase_count[g*CNT_W +: CNT_W],
                                            module_on[g], triggered_reload_select[g], reload_armed[g]);

            pcm_chan u_chan (
                .clk        (clk),
                .sys_rst    (sys_rst),
                .wr_stb     (wr_ch),
                .wr_idx     (idx),
                .wr_data    (wbyte),
                .arm_wr     (wr_arm_mirror | wr_rld),
                .arm_val    (wr_arm_mirror ? wbyte[g] : wbyte[RLD_ARMED_BIT]),
                .module_on  (module_on[g]),
                .triggered_reload_select        (triggered_reload_select[g]),
                .trigger    (ld_trigger[g]),
                .buf_lag    (buf_lag[g]),
                .buf_duty   (buf_duty[g]),
                .buf_period (buf_period[g]),
                .buf_delay  (buf_delay[g]),
                .timer      (timebase_count[g*CNT_W +: CNT_W]),
                .armed      (reload_armed[g]),
                .act_lag    (lag_active[g*CNT_W +: CNT_W]),
                .act_duty   (duty_active[g*CNT_W +: CNT_W]),
                .act_period (period_active[g*CNT_W +: CNT_W]),
                .act_delay  (delay_active[g*CNT_W +: CNT_W]),
                .period_end (period_done[g])
            );
        end
    endgenerate

    // upper mirror bits are not stored and read zero
    assign bank_byte[MIRROR_BANK] =
        (address == OFS_MODULE_ON_MIRROR)    ? BYTE_W'(module_on)    :
        (address == OFS_RELOAD_ARMED_MIRROR) ? BYTE_W'(reload_armed) : 8'h00;
    assign rd_byte = bank_byte[bank];

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            module_on <= '0;
            triggered_reload_select       <= '0;
        end else begin
            module_on <= next_module_on;
            triggered_reload_select       <= next_ldt;
        end
    end

    // checks on channel 0, a few on channels 1 and 2, and on the mirrors
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_wr(logic [ADDR_W-1:0] a);
        wr_take && address == a;
    endsequence
    sequence s_rd(logic [ADDR_W-1:0] a);
        rd_take && address == a;
    endsequence
    sequence s_load0;
        reload_armed[0] && !triggered_reload_select[0] && period_done[0];
    endsequence

    AST_LAG_HI: assert property (s_wr(reg_ofs(2'h0, IDX_LAG_HI)) |=>
        get_byte(buf_lag[0], 1'b1) == $past(wbyte)) else $error("phase high byte lost");
    AST_DUTY_LO: assert property (s_wr(reg_ofs(2'h0, IDX_DUTY_LO)) |=>
        get_byte(buf_duty[0], 1'b0) == $past(wbyte)) else $error("duty low byte lost");
    AST_PERIOD_HI: assert property (s_wr(reg_ofs(2'h1, IDX_PERIOD_HI)) |=>
        get_byte(buf_period[1], 1'b1) == $past(wbyte)) else $error("period high byte lost");
    AST_DELAY_RD: assert property (s_rd(reg_ofs(2'h2, IDX_DELAY_LO)) |=>
        readdata == DATA_W'($past(get_byte(buf_delay[2], 1'b0)))) else $error("offset readback");
    AST_TMR_RD: assert property (s_rd(reg_ofs(2'h0, IDX_TMR_HI)) |=>
        readdata == DATA_W'($past(get_byte(timebase_count[CNT_W-1:0], 1'b1))))
        else $error("timer readback");
    AST_BUF_KEEP: assert property (@(posedge clk) disable iff (1'b0)
        sys_rst |=> buf_period[0] === $past(buf_period[0])) else $error("buffer lost on reset");
    AST_ON_MIRROR: assert property (s_wr(OFS_MODULE_ON_MIRROR) |=>
        module_on == $past(wbyte[NUM_CH-1:0])) else $error("enable mirror write");
    AST_ON_CTRL: assert property (s_wr(reg_ofs(2'h1, IDX_CHAN_CTRL)) |=>
        module_on[1] == $past(wbyte[CTRL_ON_BIT])) else $error("enable control write");
    AST_ARM_MIRROR: assert property (s_wr(OFS_RELOAD_ARMED_MIRROR) |=>
        reload_armed == $past(wbyte[NUM_CH-1:0])) else $error("arm mirror write");
    AST_MIRROR_RSV: assert property (s_rd(OFS_RELOAD_ARMED_MIRROR) |=>
        readdata[DATA_W-1:NUM_CH] == '0) else $error("mirror upper bits not zero");
    AST_MIRROR_RST: assert property (@(posedge clk) disable iff (1'b0)
        $fell(sys_rst) |-> module_on == '0 && reload_armed == '0) else $error("mirror reset");
    AST_OFF_HOLD: assert property (!module_on[0] && !wr_take |=>
        timebase_count[CNT_W-1:0] === $past(timebase_count[CNT_W-1:0]))
        else $error("disabled timer moved");
    AST_ON_COUNT: assert property (module_on[0] && !period_done[0] && !wr_take |=>
        timebase_count[CNT_W-1:0] == $past(timebase_count[CNT_W-1:0]) + TIMER_STEP)
        else $error("enabled timer stalled");
    AST_RELOAD: assert property (s_load0 |=>
        period_active[CNT_W-1:0] == $past(buf_period[0])
        && lag_active[CNT_W-1:0] == $past(buf_lag[0])) else $error("reload missed");
    AST_ARM_CLEAR: assert property (s_load0 ##0 !wr_take |=> !reload_armed[0] ##1
        $stable(period_active[CNT_W-1:0]) || period_done[0]) else $error("armed not cleared");
    AST_ON_RD: assert property (s_rd(OFS_MODULE_ON_MIRROR) |=>
        readdata == DATA_W'($past(module_on))) else $error("enable mirror readback");
    AST_RLD_CTRL: assert property (s_wr(reg_ofs(2'h1, IDX_RELOAD_CTRL)) |=>
        reload_armed[1] == $past(wbyte[RLD_ARMED_BIT])) else $error("reload control arm");
    AST_NO_STRAY_LOAD: assert property (!reload_armed[0] |=>
        $stable(period_active[CNT_W-1:0])) else $error("load without arming");

endmodule // pcm_regs

// ### shared/pcm_pkg.sv
// pcm_pkg: register map, field positions and byte helpers of the pwm count registers
// assumes byte-addressed avalon-mm access, one register per aligned 32-bit word
package pcm_pkg;

    localparam int NUM_CH = 3;
    localparam int CNT_W  = 16;
    localparam int BYTE_W = 8;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // address fields: bank selects channel or mirrors, idx selects register
    localparam int BANK_MSB = 7;
    localparam int BANK_LSB = 6;
    localparam int IDX_MSB  = 5;
    localparam int IDX_LSB  = 2;

    // register index inside a channel bank; high byte sits at even index
    localparam logic [3:0] IDX_LAG_HI      = 4'h0;
    localparam logic [3:0] IDX_LAG_LO      = 4'h1;
    localparam logic [3:0] IDX_DUTY_HI     = 4'h2;
    localparam logic [3:0] IDX_DUTY_LO     = 4'h3;
    localparam logic [3:0] IDX_PERIOD_HI   = 4'h4;
    localparam logic [3:0] IDX_PERIOD_LO   = 4'h5;
    localparam logic [3:0] IDX_DELAY_HI    = 4'h6;
    localparam logic [3:0] IDX_DELAY_LO    = 4'h7;
    localparam logic [3:0] IDX_TMR_HI      = 4'h8;
    localparam logic [3:0] IDX_TMR_LO      = 4'h9;
    localparam logic [3:0] IDX_CHAN_CTRL   = 4'hA;
    localparam logic [3:0] IDX_RELOAD_CTRL = 4'hB;

    localparam logic [1:0] MIRROR_BANK = 2'h3;
    localparam logic [ADDR_W-1:0] OFS_MODULE_ON_MIRROR    = 8'hC0;
    localparam logic [ADDR_W-1:0] OFS_RELOAD_ARMED_MIRROR = 8'hC4;

    // bit positions in channel_control and reload_control
    localparam int CTRL_ON_BIT   = 7;
    localparam int RLD_ARMED_BIT = 7;
    localparam int RLD_TRIG_BIT  = 6;

    localparam logic [CNT_W-1:0] TIMER_START = 16'h0000;
    localparam logic [CNT_W-1:0] TIMER_STEP  = 16'h0001;
    localparam logic [CNT_W-1:0] ACTIVE_RST  = 16'h0000;

    function automatic logic [CNT_W-1:0] put_byte(input logic [CNT_W-1:0] old,
                                                  input logic              hi,
                                                  input logic [BYTE_W-1:0] d);
        return hi ? {d, old[BYTE_W-1:0]} : {old[CNT_W-1:BYTE_W], d};
    endfunction

    function automatic logic [BYTE_W-1:0] get_byte(input logic [CNT_W-1:0] v,
                                                   input logic             hi);
        return hi ? v[CNT_W-1:BYTE_W] : v[BYTE_W-1:0];
    endfunction

    function automatic logic [ADDR_W-1:0] reg_ofs(input logic [1:0] bank,
                                                  input logic [3:0] idx);
        return {bank, idx, 2'h0};
    endfunction

endpackage

// ### hw/pcm_avs.sv
// pcm_avs: avalon-mm slave handshake, one wait state per access, registered read data
// assumes the master holds address, direction and data until waitrequest is seen low
`timescale 1ns/1ps
module pcm_avs import pcm_pkg::*; (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              sys_rst,
    // bus side
    input  wire logic              read,
    input  wire logic              write,
    output logic                   waitrequest,
    output logic [DATA_W-1:0]      readdata,
    // register side
    input  wire logic [BYTE_W-1:0] rd_byte,
    output logic                   wr_take,
    output logic                   rd_take
);

    logic ack;
    logic next_ack;

    assign next_ack    = (read | write) & ~ack;
    assign waitrequest = (read | write) & ~ack;
    assign wr_take     = write & ack;
    // read data is caught while the request still waits
    assign rd_take     = read & ~ack;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ack <= 1'b0;
        end else begin
            ack <= next_ack;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            readdata <= '0;
        end else if (rd_take) begin
            readdata <= {{(DATA_W-BYTE_W){1'b0}}, rd_byte};
        end
    end

endmodule // pcm_avs

// ### hw/pcm_chan.sv
// pcm_chan: one channel's count buffers, values in use, timebase counter and reload arming
// assumes write strobes come from the register slave on the same clock
`timescale 1ns/1ps
module pcm_chan import pcm_pkg::*; (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              sys_rst,
    // register writes aimed at this channel
    input  wire logic              wr_stb,
    input  wire logic [3:0]        wr_idx,
    input  wire logic [BYTE_W-1:0] wr_data,
    input  wire logic              arm_wr,
    input  wire logic              arm_val,
    // control
    input  wire logic              module_on,
    input  wire logic              triggered_reload_select,
    input  wire logic              trigger,
    // software view
    output logic [CNT_W-1:0]       buf_lag,
    output logic [CNT_W-1:0]       buf_duty,
    output logic [CNT_W-1:0]       buf_period,
    output logic [CNT_W-1:0]       buf_delay,
    output logic [CNT_W-1:0]       timer,
    output logic                   armed,
    // values in use
    output logic [CNT_W-1:0]       act_lag,
    output logic [CNT_W-1:0]       act_duty,
    output logic [CNT_W-1:0]       act_period,
    output logic [CNT_W-1:0]       act_delay,
    output logic                   period_end
);

    logic trig_seen;
    logic next_armed;
    logic next_trig_seen;

    wire hi        = ~wr_idx[0];
    wire wr_lag    = wr_stb & (wr_idx == IDX_LAG_HI    || wr_idx == IDX_LAG_LO);
    wire wr_duty   = wr_stb & (wr_idx == IDX_DUTY_HI   || wr_idx == IDX_DUTY_LO);
    wire wr_period = wr_stb & (wr_idx == IDX_PERIOD_HI || wr_idx == IDX_PERIOD_LO);
    wire wr_delay  = wr_stb & (wr_idx == IDX_DELAY_HI  || wr_idx == IDX_DELAY_LO);
    wire wr_timer  = wr_stb & (wr_idx == IDX_TMR_HI    || wr_idx == IDX_TMR_LO);

    assign period_end = module_on & (timer == act_period);
    wire load_due = armed & (~triggered_reload_select | trig_seen) & period_end;

    // software arming wins over the hardware clear in the same cycle
    assign next_armed = arm_wr ? arm_val : (load_due ? 1'b0 : armed);
    assign next_trig_seen = (load_due | ~armed) ? 1'b0 : (trig_seen | (trigger & triggered_reload_select));

    // no reset: content unknown at power-up, kept over any reset
    always_ff @(posedge clk) begin
        if (wr_lag) buf_lag <= put_byte(buf_lag, hi, wr_data);
        if (wr_duty) buf_duty <= put_byte(buf_duty, hi, wr_data);
        if (wr_period) buf_period <= put_byte(buf_period, hi, wr_data);
        if (wr_delay) buf_delay <= put_byte(buf_delay, hi, wr_data);
    end

    always_ff @(posedge clk) begin
        if (wr_timer) begin
            timer <= put_byte(timer, hi, wr_data);
        end else if (period_end) begin
            timer <= TIMER_START;
        end else if (module_on) begin
            timer <= timer + TIMER_STEP;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            act_lag    <= ACTIVE_RST;
            act_duty   <= ACTIVE_RST;
            act_period <= ACTIVE_RST;
            act_delay  <= ACTIVE_RST;
        end else if (load_due) begin
            act_lag    <= buf_lag;
            act_duty   <= buf_duty;
            act_period <= buf_period;
            act_delay  <= buf_delay;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            armed     <= 1'b0;
            trig_seen <= 1'b0;
        end else begin
            armed     <= next_armed;
            trig_seen <= next_trig_seen;
        end
    end

endmodule // pcm_chan

// ### tb/tb.sv
// tb: self-checking bench for the pwm count and mirror register file
// assumes pcm_regs with one wait state per avalon access, on a 25 MHz clk
`timescale 1ns/1ps
module tb import pcm_pkg::*;;
    logic                   clk;
    logic                   sys_rst;
    logic [ADDR_W-1:0]      address;
    logic                   read;
    logic                   write;
    logic [DATA_W-1:0]      writedata;
    logic [DATA_W-1:0]      readdata;
    logic                   waitrequest;
    logic [NUM_CH-1:0]      ld_trigger;
    logic [NUM_CH*CNT_W-1:0] lag_active;
    logic [NUM_CH*CNT_W-1:0] duty_active;
    logic [NUM_CH*CNT_W-1:0] period_active;
    logic [NUM_CH*CNT_W-1:0] delay_active;
    logic [NUM_CH*CNT_W-1:0] timebase_count;
    logic [NUM_CH-1:0]      module_on;
    logic [NUM_CH-1:0]      reload_armed;
    logic [NUM_CH-1:0]      period_done;
    int                     err_total;
    int                     checks_done;
    logic [DATA_W-1:0]      q;
    logic [DATA_W-1:0]      q2;

    pcm_regs uut (
        .clk(clk), .sys_rst(sys_rst), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .ld_trigger(ld_trigger), .lag_active(lag_active), .duty_active(duty_active),
        .period_active(period_active), .delay_active(delay_active),
        .timebase_count(timebase_count), .module_on(module_on),
        .reload_armed(reload_armed), .period_done(period_done)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic tally_and_finish();
        $display("errors %0d, checks %0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp,
                       input string what);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // one avalon access; request held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic rd, input logic [7:0] a, input logic [7:0] d,
                       output logic [DATA_W-1:0] rq);
        int n;
        n = 0;
        @(posedge clk);
        address   <= a;
        writedata <= {24'h000000, d};
        read      <= rd;
        write     <= ~rd;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        rq = readdata;
        read  <= 1'b0;
        write <= 1'b0;
        if (n >= 20) begin
            err_total++;
            $display("ERROR %0t: bus access never answered", $time);
            tally_and_finish();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [DATA_W-1:0] dummy;
        bus(1'b0, a, d, dummy);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
        logic [DATA_W-1:0] v;
        bus(1'b1, a, 8'h00, v);
        chk(v, {24'h000000, exp}, what);
    endtask

    // waits until channel 0 is no longer armed, within a bound
    task automatic wait_disarm(input int limit);
        int n;
        n = 0;
        while (reload_armed[0] !== 1'b0 && n < limit) begin
            @(negedge clk);
            n++;
        end
        if (n >= limit) begin
            err_total++;
            $display("ERROR %0t: reload never happened", $time);
            tally_and_finish();
        end
    endtask

    function automatic logic [7:0] pat(input int ch, input int idx);
        return {ch[1:0], 2'b10, idx[3:0]};
    endfunction

    function automatic logic [7:0] adr(input int ch, input int idx);
        return {ch[1:0], idx[3:0], 2'b00};
    endfunction

    initial begin
        err_total = 0;
        checks_done = 0;
        sys_rst = 1'b1;
        address = 8'h00;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h00000000;
        ld_trigger = 3'h0;
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        rd_chk(8'hC0, 8'h00, "enable mirror after reset");
        rd_chk(8'hC4, 8'h00, "arm mirror after reset");
        // every count and timer byte of every channel, all channels stopped
        for (int c = 0; c < NUM_CH; c++)
            for (int i = 0; i < 10; i++)
                wr(adr(c, i), pat(c, i));
        for (int c = 0; c < NUM_CH; c++)
            for (int i = 0; i < 10; i++)
                rd_chk(adr(c, i), pat(c, i), "count byte readback");
        chk({16'h0000, lag_active[15:0]}, 32'h00000000, "active before arming");
        // enable mirror and per-channel enable are one bit
        wr(8'hC0, 8'hFF);
        rd_chk(8'hC0, 8'h07, "enable mirror upper bits");
        chk({29'h0, module_on}, 32'h00000007, "module_on after mirror write");
        rd_chk(adr(1, 10), 8'h80, "control shows mirror enable");
        wr(adr(1, 10), 8'h00);
        rd_chk(8'hC0, 8'h05, "mirror shows control enable");
        wr(8'hC0, 8'h00);
        // stopped channel keeps its count
        wr(adr(1, 9), pat(1, 9));
        repeat (4) @(posedge clk);
        rd_chk(adr(1, 9), pat(1, 9), "stopped timer holds");
        // arm channel 0, start it from count zero and wait for the reload
        wr(adr(0, 8), 8'h00);
        wr(adr(0, 9), 8'h00);
        wr(8'hC4, 8'h01);
        @(negedge clk);
        chk({29'h0, reload_armed}, 32'h00000001, "arm through mirror");
        rd_chk(adr(0, 11), 8'h80, "reload control shows arm");
        wr(8'hC0, 8'h01);
        wait_disarm(50);
        chk({29'h0, period_done}, 32'h00000000, "no period end after reload");
        chk({16'h0, lag_active[15:0]}, {16'h0, pat(0, 0), pat(0, 1)}, "lag loaded");
        chk({16'h0, duty_active[15:0]}, {16'h0, pat(0, 2), pat(0, 3)}, "duty loaded");
        chk({16'h0, period_active[15:0]}, {16'h0, pat(0, 4), pat(0, 5)}, "period loaded");
        chk({16'h0, delay_active[15:0]}, {16'h0, pat(0, 6), pat(0, 7)}, "delay loaded");
        chk({16'h0, lag_active[31:16]}, 32'h00000000, "other channel untouched");
        rd_chk(8'hC4, 8'h00, "arm cleared by reload");
        // running count moves between reads
        bus(1'b1, adr(0, 9), 8'h00, q);
        bus(1'b1, adr(0, 9), 8'h00, q2);
        chk({31'h0, q !== q2}, 32'h00000001, "running timer advances");
        // triggered reload waits for the trigger, then loads at the period end
        wr(adr(0, 5), 8'h10);
        wr(adr(0, 11), 8'hC0);
        ld_trigger <= 3'h1;
        @(posedge clk);
        ld_trigger <= 3'h0;
        wait_disarm(10000);
        chk({16'h0, period_active[15:0]}, {16'h0, pat(0, 4), 8'h10}, "triggered reload");
        // software cancels an arming on a stopped channel
        wr(adr(1, 11), 8'h80);
        rd_chk(8'hC4, 8'h02, "arm via reload control");
        wr(adr(1, 11), 8'h00);
        rd_chk(8'hC4, 8'h00, "software cancel");
        wr(8'hC4, 8'hFE);
        rd_chk(8'hC4, 8'h06, "arm mirror upper bits");
        rd_chk(adr(2, 11), 8'h80, "reload control via mirror");
        wr(8'hC4, 8'h00);
        // unmapped places read zero
        rd_chk(8'h30, 8'h00, "unmapped index");
        rd_chk(8'hC8, 8'h00, "unmapped mirror slot");
        // reset in mid-run: mirrors clear, buffers survive
        wr(8'hC4, 8'h04);
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        @(negedge clk);
        chk({29'h0, module_on}, 32'h00000000, "enables after reset");
        chk({29'h0, reload_armed}, 32'h00000000, "arms after reset");
        rd_chk(adr(2, 0), pat(2, 0), "lag survives reset");
        rd_chk(adr(2, 7), pat(2, 7), "delay survives reset");
        rd_chk(8'hC0, 8'h00, "enable mirror reset");
        tally_and_finish();
    end
endmodule // tb
